// [src/iec_counter_inputs.sv]
`timescale 1ns/1ps
`default_nettype none
module iec_counter_inputs
   import iec_pkg::*;
#(
   parameter int COUNT_W = 32
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // encoder tracks (asynchronous pins)
   input wire logic track_a,
   input wire logic track_b,
   input wire logic track_n,
   // avalon-mm slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // counter core side
   output logic count_pulse,
   output logic count_up,
   output logic index_event,
   // physical output pin
   output logic second_compare_output
);
   import iec_pkg::*;

   // --------------------------------------------------------------
   // declarations
   // --------------------------------------------------------------
   iec_track_t trk;
   iec_track_t trk_prev;
   iec_cfg_t cfg;
   logic dir_down;
   logic [COUNT_W-1:0] start_value;
   logic [COUNT_W-1:0] cmp_first;
   logic [COUNT_W-1:0] cmp_second;
   logic [COUNT_W-1:0] count;
   logic [COUNT_W-1:0] capture;
   logic [COUNT_W-1:0] next_count;
   logic dir_up;
   logic sync_done;
   logic cap_done;
   logic first_compare_output;
   logic dec_step;
   logic dec_up;
   logic step;
   logic n_rise;
   logic index_used;
   logic do_sync;
   logic do_capture;
   logic bus_req;
   logic bus_done;
   logic wr_cfg;
   logic wr_ctrl;
   logic ctrl_ok;
   logic rearm;
   logic [31:0] rd_word;

   // signed comparison of count against a threshold
   function automatic logic cmp_hit(input logic [COUNT_W-1:0] value, input logic [COUNT_W-1:0] limit);
      cmp_hit = $signed(value) >= $signed(limit);
   endfunction : cmp_hit

   // byte-enable merge of a write into a stored word
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      be_merge = res;
   endfunction : be_merge

   // --------------------------------------------------------------
   // track synchronisation and edge history
   // --------------------------------------------------------------
   iec_sync #(
      .WIDTH(3)
   ) u_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .async_in({track_n, track_b, track_a}),
      .sync_out(trk)
   );

   // previous level, taken from the second stage only
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         trk_prev <= '0;
      end else begin
         trk_prev <= trk;
      end
   end

   // --------------------------------------------------------------
   // decoding of counts and direction
   // --------------------------------------------------------------
   iec_decode u_decode (
      .cur(trk),
      .prev(trk_prev),
      .cfg(cfg),
      .dir_down(dir_down),
      .step(dec_step),
      .up(dec_up)
   );

   // inactive channel looks at no track input at all
   assign step = cfg.enable & dec_step;
   assign index_used = cfg.enable & (iec_sig_t'(cfg.sig_type) == IEC_SIG_QUAD_ABN);
   assign n_rise = index_used & trk.n & ~trk_prev.n;

   // index reactions
   assign do_sync = n_rise & (iec_nreact_t'(cfg.n_react) == IEC_N_SYNC) &
                    (cfg.sync_periodic | ~sync_done);
   assign do_capture = n_rise & (iec_nreact_t'(cfg.n_react) == IEC_N_CAPTURE) &
                       (~cfg.capture_once | ~cap_done);

   // --------------------------------------------------------------
   // counter value; start-value load beats a count step
   // --------------------------------------------------------------
   always_comb begin
      next_count = count;
      if (do_sync) begin
         next_count = start_value;
      end else if (step) begin
         next_count = dec_up ? count + 1'b1 : count - 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         count <= '0;
      end else if (!cfg.enable) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   // direction of the last counted step
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         dir_up <= 1'b0;
      end else if (step) begin
         dir_up <= dec_up;
      end
   end

   // capture register
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         capture <= '0;
      end else if (do_capture) begin
         capture <= count;
      end
   end

   // --------------------------------------------------------------
   // once-only flags; a new event beats a re-arm clear
   // --------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sync_done <= 1'b0;
         cap_done <= 1'b0;
      end else if (!cfg.enable) begin
         sync_done <= 1'b0;
         cap_done <= 1'b0;
      end else begin
         if (do_sync) begin
            sync_done <= 1'b1;
         end else if (rearm) begin
            sync_done <= 1'b0;
         end
         if (do_capture) begin
            cap_done <= 1'b1;
         end else if (rearm) begin
            cap_done <= 1'b0;
         end
      end
   end

   // --------------------------------------------------------------
   // comparison outputs
   // --------------------------------------------------------------
   // first compare output exists only as a feedback bit, no pin
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         first_compare_output <= 1'b0;
      end else begin
         first_compare_output <= cfg.enable & cmp_hit(next_count, cmp_first);
      end
   end

   // second compare output drives a pin, silent when inactive
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         second_compare_output <= 1'b0;
      end else begin
         second_compare_output <= cfg.enable & cmp_hit(next_count, cmp_second);
      end
   end

   // --------------------------------------------------------------
   // counter core outputs, registered
   // --------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         count_pulse <= 1'b0;
         count_up <= 1'b0;
         index_event <= 1'b0;
      end else begin
         count_pulse <= step;
         count_up <= step ? dec_up : count_up;
         index_event <= n_rise;
      end
   end

   // --------------------------------------------------------------
   // bus handshake: one wait cycle, then completion
   // --------------------------------------------------------------
   assign bus_req = avs_read | avs_write;
   assign bus_done = bus_req & ~avs_waitrequest;
   assign wr_cfg = bus_done & avs_write & (avs_address == IEC_ADDR_CONFIG);
   assign ctrl_ok = bus_done & avs_write & cfg.enable;
   assign wr_ctrl = ctrl_ok & (avs_address == IEC_ADDR_CONTROL);
   assign rearm = wr_ctrl & avs_byteenable[0] & avs_writedata[IEC_CTRL_REARM];

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
      end else if (bus_req && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // configuration register, writable at any time
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cfg <= IEC_CFG_RESET;
      end else if (wr_cfg) begin
         cfg <= iec_cfg_t'(IEC_CFG_W'(be_merge({21'h0, cfg}, avs_writedata,
                                               avs_byteenable)));
      end
   end

   // control interface words, dropped while inactive
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         dir_down <= 1'b0;
         start_value <= IEC_WORD_RESET;
         cmp_first <= IEC_WORD_RESET;
         cmp_second <= IEC_WORD_RESET;
      end else if (ctrl_ok) begin
         unique case (avs_address)
            IEC_ADDR_CONTROL: begin
               if (avs_byteenable[0]) begin
                  dir_down <= avs_writedata[IEC_CTRL_DIR_DOWN];
               end
            end
            IEC_ADDR_START: start_value <= be_merge(start_value, avs_writedata, avs_byteenable);
            IEC_ADDR_CMP_FIRST: cmp_first <= be_merge(cmp_first, avs_writedata, avs_byteenable);
            IEC_ADDR_CMP_SECOND: cmp_second <= be_merge(cmp_second, avs_writedata, avs_byteenable);
            default: begin
            end
         endcase
      end
   end

   // --------------------------------------------------------------
   // read multiplexer; feedback reads zero while inactive
   // --------------------------------------------------------------
   always_comb begin
      rd_word = 32'h0000_0000;
      case (avs_address)
         IEC_ADDR_CONFIG: rd_word = {21'h0, cfg};
         IEC_ADDR_CONTROL: rd_word = {31'h0, dir_down};
         IEC_ADDR_START: rd_word = start_value;
         IEC_ADDR_CMP_FIRST: rd_word = cmp_first;
         IEC_ADDR_CMP_SECOND: rd_word = cmp_second;
         IEC_ADDR_COUNT: rd_word = cfg.enable ? count : 32'h0000_0000;
         IEC_ADDR_CAPTURE: rd_word = cfg.enable ? capture : 32'h0000_0000;
         IEC_ADDR_STATUS: begin
            if (cfg.enable) begin
               rd_word[IEC_STS_DIR_UP] = dir_up;
               rd_word[IEC_STS_CMP_FIRST] = first_compare_output;
               rd_word[IEC_STS_CMP_SECOND] = second_compare_output;
               rd_word[IEC_STS_SYNC_DONE] = sync_done;
               rd_word[IEC_STS_CAP_DONE] = cap_done;
               rd_word[IEC_STS_TRACK_A] = trk.a;
               rd_word[IEC_STS_TRACK_B] = trk.b;
               rd_word[IEC_STS_TRACK_N] = trk.n;
            end
         end
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // read data latched with the falling of waitrequest
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && avs_waitrequest) begin
         avs_readdata <= rd_word;
      end
   end

endmodule : iec_counter_inputs
`default_nettype wire

// [src/iec_pkg.sv]
package iec_pkg;

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] IEC_ADDR_CONFIG = 8'h00;
   localparam logic [7:0] IEC_ADDR_CONTROL = 8'h04;
   localparam logic [7:0] IEC_ADDR_START = 8'h08;
   localparam logic [7:0] IEC_ADDR_CMP_FIRST = 8'h0C;
   localparam logic [7:0] IEC_ADDR_CMP_SECOND = 8'h10;
   localparam logic [7:0] IEC_ADDR_COUNT = 8'h14;
   localparam logic [7:0] IEC_ADDR_CAPTURE = 8'h18;
   localparam logic [7:0] IEC_ADDR_STATUS = 8'h1C;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int IEC_CTRL_DIR_DOWN = 0;
   localparam int IEC_CTRL_REARM = 1;
   localparam int IEC_STS_DIR_UP = 0;
   localparam int IEC_STS_CMP_FIRST = 1;
   localparam int IEC_STS_CMP_SECOND = 2;
   localparam int IEC_STS_SYNC_DONE = 3;
   localparam int IEC_STS_CAP_DONE = 4;
   localparam int IEC_STS_TRACK_A = 5;
   localparam int IEC_STS_TRACK_B = 6;
   localparam int IEC_STS_TRACK_N = 7;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      IEC_SIG_QUAD_AB, IEC_SIG_QUAD_ABN, IEC_SIG_PULSE_DIR, IEC_SIG_PULSE, IEC_SIG_UP_DOWN
   } iec_sig_t;
   typedef enum logic [1:0] {IEC_EVAL_SINGLE, IEC_EVAL_DOUBLE, IEC_EVAL_QUAD} iec_eval_t;
   typedef enum logic [1:0] {IEC_N_NONE, IEC_N_SYNC, IEC_N_CAPTURE} iec_nreact_t;

   // configuration word, bit 0 upward: enable, type, invert, eval, index reaction, sync periodic, capture once
   typedef struct packed {
      logic capture_once;
      logic sync_periodic;
      logic [1:0] n_react;
      logic [1:0] eval;
      logic invert;
      logic [2:0] sig_type;
      logic enable;
   } iec_cfg_t;
   localparam int IEC_CFG_W = 11;

   // synchronised track levels
   typedef struct packed {
      logic n;
      logic b;
      logic a;
   } iec_track_t;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam iec_cfg_t IEC_CFG_RESET = 11'h400;  // off, quad A/B, single, capture once
   localparam logic [31:0] IEC_WORD_RESET = 32'h0000_0000;

endpackage : iec_pkg

// [src/iec_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module iec_sync #(
   parameter int WIDTH = 3
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   // --------------------------------------------------------------
   // two-flop synchroniser; first stage read only by second
   // --------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : iec_sync
`default_nettype wire

// [src/iec_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module iec_decode
   import iec_pkg::*;
(
   // track levels, now and one cycle before
   input wire iec_pkg::iec_track_t cur,
   input wire iec_pkg::iec_track_t prev,
   // settings
   input wire iec_pkg::iec_cfg_t cfg,
   input wire logic dir_down,
   // decoded step
   output logic step,
   output logic up
);
   logic edge_a;
   logic edge_b;
   logic rise_a;
   logic rise_b;
   logic quad_up;
   logic quad_step;

   // edge detection on synchronised tracks
   assign edge_a = cur.a ^ prev.a;
   assign edge_b = cur.b ^ prev.b;
   assign rise_a = cur.a & ~prev.a;
   assign rise_b = cur.b & ~prev.b;

   // --------------------------------------------------------------
   // quadrature: phase order gives direction, eval picks edges
   // --------------------------------------------------------------
   always_comb begin
      quad_step = 1'b0;
      quad_up = 1'b0;
      if (edge_a && !edge_b) begin
         quad_up = cur.a ^ cur.b;
         case (iec_eval_t'(cfg.eval))
            IEC_EVAL_SINGLE: quad_step = ~cur.b;
            IEC_EVAL_DOUBLE: quad_step = 1'b1;
            IEC_EVAL_QUAD: quad_step = 1'b1;
            default: quad_step = 1'b0;
         endcase
      end else if (edge_b && !edge_a) begin
         quad_up = ~(cur.a ^ cur.b);
         quad_step = (iec_eval_t'(cfg.eval) == IEC_EVAL_QUAD);
      end
   end

   // --------------------------------------------------------------
   // signal type selects the decoder
   // --------------------------------------------------------------
   always_comb begin
      step = 1'b0;
      up = 1'b1;
      case (iec_sig_t'(cfg.sig_type))
         IEC_SIG_QUAD_AB, IEC_SIG_QUAD_ABN: begin
            step = quad_step;
            up = quad_up ^ cfg.invert;
         end
         IEC_SIG_PULSE_DIR: begin
            step = rise_a;
            up = ~cur.b;
         end
         IEC_SIG_PULSE: begin
            step = rise_a;
            up = ~dir_down;
         end
         IEC_SIG_UP_DOWN: begin
            step = rise_a ^ rise_b;
            up = rise_a;
         end
         default: begin
            step = 1'b0;
            up = 1'b1;
         end
      endcase
   end
endmodule : iec_decode
`default_nettype wire

// [tb/iec_encoder_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// encoder model: each track moves just after an edge, then stands
// ------------------------------------------------------------
module iec_encoder_model (
   // clock
   input wire logic sys_clk,
   // tracks towards the channel
   output logic track_a,
   output logic track_b,
   output logic track_n
);
   int hold_cyc = 3;

   // push-pull outputs, all low at power-up
   initial begin
      track_a = 1'b0;
      track_b = 1'b0;
      track_n = 1'b0;
   end

   // move one track, then keep every track still for hold_cyc edges
   task automatic drive(input int t, input logic v);
      @(posedge sys_clk);
      if (t == 0) track_a <= v;
      else if (t == 1) track_b <= v;
      else track_n <= v;
      repeat (hold_cyc) @(posedge sys_clk);
   endtask : drive

   // one quadrature step; up means the first track leads
   task automatic quad_step(input logic up, output logic tog_a);
      tog_a = ((track_a == track_b) == up);
      drive(tog_a ? 0 : 1, tog_a ? !track_a : !track_b);
   endtask : quad_step

   // full pulse: rise, stand, fall, stand (track 2 is the index)
   task automatic pulse(input int t);
      drive(t, 1'b1);
      drive(t, 1'b0);
   endtask : pulse
endmodule : iec_encoder_model
`default_nettype wire

// [tb/iec_counter_inputs_props.sv]
`timescale 1ns/1ps
`default_nettype none
module iec_counter_inputs_props
   import iec_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // tracks
   input wire logic track_a,
   input wire logic track_b,
   input wire logic track_n,
   // avalon-mm
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // core side and pin
   input wire logic count_pulse,
   input wire logic count_up,
   input wire logic index_event,
   input wire logic second_compare_output
);
   logic acc;
   logic en;
   logic [2:0] typ;
   logic [2:0] dis_cnt;

   assign acc = (avs_read || avs_write) && !avs_waitrequest;

   // shadow of enable and signal type, taken at the accepting edge
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         en <= 1'b0;
         typ <= 3'h0;
      end else if (acc && avs_write && avs_address == IEC_ADDR_CONFIG && avs_byteenable[0]) begin
         en <= avs_writedata[0];
         typ <= avs_writedata[3:1];
      end
   end

   // cycles since the channel was switched off, saturating
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) dis_cnt <= 3'h0;
      else if (en) dis_cnt <= 3'h0;
      else if (dis_cnt != 3'h7) dis_cnt <= dis_cnt + 3'h1;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus access not answered in one cycle");
   AST_BUS_IDLE: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
      else $error("waitrequest low with no request");
   AST_DIS_QUIET: assert property (dis_cnt >= 3'h4 |-> !count_pulse && !index_event && !second_compare_output)
      else $error("inactive channel drives an output");
   AST_DIS_ZERO: assert property (dis_cnt >= 3'h4 && acc && avs_read && avs_address >= IEC_ADDR_COUNT |-> avs_readdata == 32'h0)
      else $error("inactive channel returns nonzero feedback");
   AST_PULSE_CAUSE: assert property (count_pulse |-> $past(track_a, 3) != $past(track_a, 4) || $past(track_b, 3) != $past(track_b, 4))
      else $error("count pulse without a track edge three cycles before");
   AST_INDEX_CAUSE: assert property (index_event |-> $past(track_n, 3) && !$past(track_n, 4))
      else $error("index event without a rising index edge");
   AST_DIR_HOLD: assert property ($changed(count_up) |-> count_pulse)
      else $error("direction changed between counts");
   AST_UPDOWN_DIR: assert property (count_pulse && typ == IEC_SIG_UP_DOWN |-> count_up == ($past(track_a, 3) != $past(track_a, 4)))
      else $error("up/down direction wrong");
   AST_PDIR_DIR: assert property (count_pulse && typ == IEC_SIG_PULSE_DIR |-> count_up == !$past(track_b, 3))
      else $error("pulse and direction level not followed");

   CV_UP: cover property (count_pulse && count_up);
   CV_DOWN: cover property (count_pulse && !count_up);
   CV_INDEX: cover property (index_event);
endmodule : iec_counter_inputs_props

bind iec_counter_inputs iec_counter_inputs_props i_props (
   .sys_clk(sys_clk), .reset(reset), .track_a(track_a), .track_b(track_b), .track_n(track_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .count_pulse(count_pulse), .count_up(count_up), .index_event(index_event),
   .second_compare_output(second_compare_output)
);
`default_nettype wire

// [tb/iec_counter_inputs_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module iec_counter_inputs_tb_top;
   import iec_pkg::*;
   // ------------------------------------------------------------
   // signals and model state
   // ------------------------------------------------------------
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic track_a, track_b, track_n, avs_waitrequest, count_pulse, count_up, index_event, second_compare_output;
   logic [2:0] ty;
   logic [1:0] ev;
   logic inv, ddn, tga;
   int num_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   int obs_cnt = 0;
   int idx_cnt = 0;
   int exp_cnt, exp_steps, obs0, idx0, thr1, thr2, start, cap, done;

   always #50 sys_clk = ~sys_clk;

   iec_counter_inputs i_dut (.sys_clk(sys_clk), .reset(reset), .track_a(track_a), .track_b(track_b),
      .track_n(track_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .count_pulse(count_pulse), .count_up(count_up),
      .index_event(index_event), .second_compare_output(second_compare_output));
   iec_encoder_model i_enc (.sys_clk(sys_clk), .track_a(track_a), .track_b(track_b), .track_n(track_n));

   // tally of core-side pulses, and the hang limit
   always @(posedge sys_clk) begin
      cyc++;
      if (count_pulse === 1'b1) obs_cnt += (count_up === 1'b1) ? 1 : -1;
      if (index_event === 1'b1) idx_cnt++;
      if (cyc == 60000) begin
         num_errors++;
         $display("MISMATCH %0t timeout", $time);
         test_done();
      end
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= (a == IEC_ADDR_CONTROL) ? 4'h1 : 4'hF;
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask : rd

   task automatic bump(input logic up);
      exp_cnt += up ? 1 : -1;
      exp_steps += up ? 1 : -1;
   endtask : bump

   // switch off (clears count and once flags), then on with new settings
   task automatic setup(input logic [2:0] t, input logic [1:0] e, input logic i, input logic [1:0] nr, input logic f);
      wr(IEC_ADDR_CONFIG, 32'h0000_0400);
      i_enc.drive(0, 1'b0);
      i_enc.drive(1, 1'b0);
      wr(IEC_ADDR_CONFIG, {21'h0, f, f, nr, e, i, t, 1'b1});
      ddn = 1'($urandom_range(1));
      thr1 = int'($urandom_range(6)) - 3;
      thr2 = int'($urandom_range(6)) - 3;
      wr(IEC_ADDR_CONTROL, {31'h0, ddn});
      wr(IEC_ADDR_CMP_FIRST, 32'(thr1));
      wr(IEC_ADDR_CMP_SECOND, 32'(thr2));
      i_enc.hold_cyc = $urandom_range(6, 3);
      {ty, ev, inv} = {t, e, i};
      {exp_cnt, exp_steps, obs0, idx0} = {32'h0, 32'h0, obs_cnt, idx_cnt};
   endtask : setup

   // one random track move and its predicted effect
   task automatic op();
      logic sel;
      sel = 1'($urandom_range(1));
      if (ty <= 3'h1) begin
         i_enc.quad_step(sel, tga);
         if (tga ? (ev != 2'h0 || !track_b) : ev == 2'h2) bump(sel ^ inv);
      end else if (sel && ty == IEC_SIG_PULSE_DIR) begin
         i_enc.drive(1, !track_b);
      end else if (sel) begin
         i_enc.pulse(1);
         if (ty == IEC_SIG_UP_DOWN) bump(1'b0);
      end else begin
         i_enc.pulse(0);
         bump(ty == IEC_SIG_PULSE_DIR ? !track_b : (ty == IEC_SIG_PULSE ? !ddn : 1'b1));
      end
   endtask : op

   task automatic verify();
      logic [31:0] q;
      repeat (6) @(posedge sys_clk);
      rd(IEC_ADDR_COUNT, q);
      chk(q, 32'(exp_cnt), "count");
      chk(32'(obs_cnt - obs0), 32'(exp_steps), "pulses");
      rd(IEC_ADDR_STATUS, q);
      chk({30'h0, q[2:1]}, {30'h0, exp_cnt >= thr2, exp_cnt >= thr1}, "compare");
      chk({31'h0, second_compare_output}, {31'h0, exp_cnt >= thr2}, "pin");
   endtask : verify

   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] q;
      int s;
      s = $urandom(32'h23FD);
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      rd(IEC_ADDR_CONFIG, q);
      chk(q, 32'(IEC_CFG_RESET), "config reset");
      wr(IEC_ADDR_CONTROL, 32'h1);
      obs0 = obs_cnt;
      repeat (3) i_enc.pulse(0);
      wr(8'h24, 32'hFFFF_FFFF);
      rd(IEC_ADDR_COUNT, q);
      chk(q, 32'h0, "idle count");
      rd(IEC_ADDR_STATUS, q);
      chk(q, 32'h0, "idle status");
      rd(8'h24, q);
      chk(q, 32'h0, "unmapped");
      chk(32'(obs_cnt - obs0), 32'h0, "idle pulses");
      wr(IEC_ADDR_CONFIG, {28'h0, IEC_SIG_PULSE, 1'b1});
      i_enc.pulse(0);
      repeat (6) @(posedge sys_clk);
      rd(IEC_ADDR_COUNT, q);
      chk(q, 32'h1, "dropped control write");
      for (int t = 0; t < 5; t++) begin
         for (int v = 0; v < 6; v++) begin
            setup(3'(t), 2'(v % 3), v >= 3, IEC_N_NONE, 1'b0);
            repeat (12) op();
            verify();
         end
      end
      for (int m = 0; m < 4; m++) begin
         setup(IEC_SIG_QUAD_ABN, IEC_EVAL_QUAD, m[0], (m < 2) ? IEC_N_SYNC : IEC_N_CAPTURE, m[0]);
         start = $urandom_range(99);
         wr(IEC_ADDR_START, 32'(start));
         {done, cap} = {32'h0, 32'h0};
         repeat (2) begin
            repeat (3) op();
            i_enc.pulse(2);
            if (m < 2 && (m[0] || done == 0)) exp_cnt = start;
            if (m >= 2 && (!m[0] || done == 0)) cap = exp_cnt;
            done = 1;
         end
         repeat (3) op();
         verify();
         chk(32'(idx_cnt - idx0), 32'h2, "index events");
         rd(IEC_ADDR_CAPTURE, q);
         if (m >= 2) chk(q, 32'(cap), "capture");
      end
      test_done();
   end
endmodule : iec_counter_inputs_tb_top
`default_nettype wire
